// [outstation_reply_generator.sv]
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "outstation_map.svh"

module outstation_reply_generator
    import outstation_pkg::*;
#(
    parameter int TICK_CYCLES = `DWELL_UNIT_CYC
) (
    // Clock, reset, enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // Parsed command from the base station
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_SRC,
    input wire logic [7:0] CMD_CODE,
    input wire logic [47:0] CMD_ARG,
    output logic CMD_READY,
    // Reply byte stream
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    input wire logic TX_READY,
    // Local measurements and pins
    input wire logic [9:0] BATTERY_LEVEL,
    input wire logic PULSE_IN,
    output logic [7:0] DIG_OUT,
    output logic [39:0] ANA_OUT,
    output logic [15:0] CHANNEL,
    output logic TX_POWER_HIGH,
    output logic STORE_PULSE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Lowest port selected by a bit mask
    function automatic logic [1:0] low_port(input logic [7:0] mask);
        logic [1:0] p;
        p = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (mask[i]) begin
                p = 2'(i);
            end
        end
        return p;
    endfunction

    // Low byte of code plus payload bytes
    function automatic logic [7:0] csum(input logic [7:0] code, input logic [5:0][7:0] pay,
                                        input logic [2:0] n);
        logic [7:0] s;
        s = code;
        for (int i = 0; i < 6; i++) begin
            if (3'(i) < n) begin
                s = s + pay[i];
            end
        end
        return s;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    state_t s_r;
    state_t s_nxt;

    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] a4;
    logic [7:0] a5;
    logic [1:0] pi;
    logic tick;
    logic last_byte;

    // Payload bytes, first byte after the code in the top lane
    assign a0 = CMD_ARG[47:40];
    assign a1 = CMD_ARG[39:32];
    assign a2 = CMD_ARG[31:24];
    assign a3 = CMD_ARG[23:16];
    assign a4 = CMD_ARG[15:8];
    assign a5 = CMD_ARG[7:0];
    assign pi = low_port(a0);
    assign tick = (s_r.tick_cnt == 20'(TICK_CYCLES - 1));
    assign last_byte = (s_r.idx == s_r.len - 4'h1);

    // Handshakes and pin outputs
    assign CMD_READY = (s_r.st == S_IDLE);
    assign TX_VALID = (s_r.st == S_SEND);
    assign TX_DATA = s_r.frame[s_r.idx];
    assign TX_LAST = (s_r.st == S_SEND) && last_byte;
    assign DIG_OUT = s_r.dout;
    assign ANA_OUT = s_r.ao_level;
    assign CHANNEL = s_r.channel;
    assign TX_POWER_HIGH = s_r.tx_high;
    assign STORE_PULSE = s_r.store;
    assign REG_RDATA = s_r.rdata;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [5:0][7:0] pay;
        logic [2:0] n;
        logic [7:0] code;
        logic ok;
        pay = '0;
        n = 3'h0;
        code = 8'h00;
        ok = 1'b1;
        s_nxt = s_r;
        s_nxt.store = 1'b0;

        // Command decode, store settings and build the reply payload
        if (s_r.st == S_IDLE && CMD_VALID) begin
            case (CMD_CODE)
                `CMD_POLL: begin
                    code = `RPL_POLL;
                    pay[0] = {6'h00, BATTERY_LEVEL[9:8]};
                    pay[1] = BATTERY_LEVEL[7:0];
                    n = 3'h2;
                end
                `CMD_DIN_SET, `CMD_DIN_READ: begin
                    if (CMD_CODE == `CMD_DIN_SET) begin
                        for (int i = 0; i < 4; i++) begin
                            if (a0[i]) begin
                                // Poll counter only on port zero
                                s_nxt.di_alarm[i] = (a1[1:0] == `ALARM_POLL_CNT && i != 0) ?
                                    `ALARM_OFF : a1[1:0];
                                s_nxt.di_dwell[i] = a2;
                                s_nxt.di_rise[i] = a3[0];
                            end
                        end
                    end
                    code = `RPL_DIN;
                    pay[0] = a0;
                    pay[1] = {6'h00, s_nxt.di_alarm[pi]};
                    pay[2] = s_nxt.di_dwell[pi];
                    pay[3] = {7'h00, s_nxt.di_rise[pi]};
                    n = 3'h4;
                end
                `CMD_AIN_SET, `CMD_AIN_READ: begin
                    if (CMD_CODE == `CMD_AIN_SET) begin
                        for (int i = 0; i < 4; i++) begin
                            if (a0[i]) begin
                                s_nxt.ai_type[i] = a1[1:0];
                                s_nxt.ai_trip[i] = {a2[1:0], a3};
                                s_nxt.ai_dwell[i] = a4;
                                s_nxt.ai_above[i] = a5[0];
                            end
                        end
                    end
                    code = `RPL_AIN;
                    pay[0] = a0;
                    pay[1] = {6'h00, s_nxt.ai_type[pi]};
                    pay[2] = {6'h00, s_nxt.ai_trip[pi][9:8]};
                    pay[3] = s_nxt.ai_trip[pi][7:0];
                    pay[4] = s_nxt.ai_dwell[pi];
                    pay[5] = {7'h00, s_nxt.ai_above[pi]};
                    n = 3'h6;
                end
                `CMD_AOUT_SET: begin
                    s_nxt.ao_level[a0[1:0]] = {a1[1:0], a2};
                    code = `RPL_AOUT;
                    pay[0] = a0;
                    pay[1] = {6'h00, a1[1:0]};
                    pay[2] = a2;
                    n = 3'h3;
                end
                `CMD_DOUT_SET: begin
                    s_nxt.dout = a0;
                    code = `RPL_DOUT;
                    pay[0] = a0;
                    n = 3'h1;
                end
                `CMD_PULSE_SET: begin
                    s_nxt.pulse_en = a0[0];
                    s_nxt.pulse_dwell = a1;
                    code = `RPL_PULSE;
                    pay[0] = {7'h00, a0[0]};
                    pay[1] = a1;
                    n = 3'h2;
                end
                `CMD_BATT_SET: begin
                    s_nxt.batt_trip = {a0[1:0], a1};
                    code = `RPL_BATT;
                    pay[0] = {6'h00, a0[1:0]};
                    pay[1] = a1;
                    n = 3'h2;
                end
                `CMD_STORE: begin
                    s_nxt.store = 1'b1;
                    code = `RPL_STORE;
                end
                `CMD_CHAN_SET: begin
                    // New channel held back until the acknowledgement leaves
                    s_nxt.chan_pend = {a0, a1};
                    s_nxt.chan_wait = 1'b1;
                    code = `RPL_CHAN;
                    pay[0] = a0;
                    pay[1] = a1;
                    n = 3'h2;
                end
                `CMD_POWER_SET: begin
                    // Power switches now, before the reply starts
                    s_nxt.tx_high = a0[0] ? `POWER_HIGH : `POWER_LOW;
                    code = `RPL_POWER;
                    pay[0] = {7'h00, a0[0]};
                    n = 3'h1;
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
            if (ok) begin
                s_nxt.frame = '0;
                s_nxt.frame[0] = `FRAME_LEAD;
                s_nxt.frame[1] = s_r.node_id;
                s_nxt.frame[2] = CMD_SRC;
                s_nxt.frame[3] = code;
                for (int i = 0; i < 6; i++) begin
                    if (3'(i) < n) begin
                        s_nxt.frame[`FRAME_HDR + i] = pay[i];
                    end
                end
                s_nxt.frame[`FRAME_HDR + n] = csum(code, pay, n);
                s_nxt.len = 4'(`FRAME_HDR + 1) + 4'(n);
                s_nxt.idx = 4'h0;
                s_nxt.st = S_SEND;
            end
        end

        // Byte stream out
        if (s_r.st == S_SEND && TX_READY) begin
            if (last_byte) begin
                s_nxt.st = S_IDLE;
                if (s_r.chan_wait) begin
                    s_nxt.channel = s_r.chan_pend;
                    s_nxt.chan_wait = 1'b0;
                end
            end else begin
                s_nxt.idx = s_r.idx + 4'h1;
            end
        end

        // Dwell time base, one tick per 10 ms
        s_nxt.tick_cnt = tick ? 20'h00000 : s_r.tick_cnt + 20'h00001;

        // Pulse input: new level accepted after dwell ticks of stability
        if (PULSE_IN == s_r.pin_level) begin
            s_nxt.dwell_cnt = 8'h00;
        end else if (s_r.pulse_dwell == 8'h00 || s_r.dwell_cnt >= s_r.pulse_dwell) begin
            s_nxt.pin_level = PULSE_IN;
            s_nxt.dwell_cnt = 8'h00;
            if (PULSE_IN && s_r.pulse_en) begin
                s_nxt.pulse_count = s_r.pulse_count + 16'h0001;
            end
        end else if (tick) begin
            s_nxt.dwell_cnt = s_r.dwell_cnt + 8'h01;
        end

        // Register writes
        if (REG_WR) begin
            case (REG_ADDR)
                `REG_NODE_ID: s_nxt.node_id = REG_WDATA[7:0];
                `REG_PULSE_COUNT: s_nxt.pulse_count = 16'h0000;
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle
        if (REG_RD) begin
            case (REG_ADDR)
                `REG_NODE_ID: s_nxt.rdata = {24'h000000, s_r.node_id};
                `REG_STATUS: s_nxt.rdata = {28'h0000000, s_r.chan_wait, s_r.pulse_en,
                                            s_r.tx_high, s_r.st == S_SEND};
                `REG_CHANNEL: s_nxt.rdata = {16'h0000, s_r.channel};
                `REG_PULSE_COUNT: s_nxt.rdata = {16'h0000, s_r.pulse_count};
                `REG_BATT_TRIP: s_nxt.rdata = {22'h000000, s_r.batt_trip};
                `REG_DOUT: s_nxt.rdata = {24'h000000, s_r.dout};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registered state
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.node_id <= `NODE_ID_RST;
            s_r.channel <= `CHANNEL_RST;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

endmodule
`default_nettype wire

// [outstation_map.svh]
`ifndef OUTSTATION_MAP_SVH
`define OUTSTATION_MAP_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_LEAD 8'h04
`define BASE_NODE_ID 8'h00
`define FRAME_BYTES 11
`define FRAME_HDR 4

// ----------------------------------------------------------------------------
// Command codes from the base station
// ----------------------------------------------------------------------------
`define CMD_POLL 8'h20
`define CMD_DIN_SET 8'h21
`define CMD_AIN_SET 8'h22
`define CMD_AOUT_SET 8'h23
`define CMD_DOUT_SET 8'h24
`define CMD_PULSE_SET 8'h25
`define CMD_BATT_SET 8'h26
`define CMD_STORE 8'h27
`define CMD_CHAN_SET 8'h28
`define CMD_POWER_SET 8'h29
`define CMD_DIN_READ 8'h31
`define CMD_AIN_READ 8'h32

// ----------------------------------------------------------------------------
// Reply codes to the base station
// ----------------------------------------------------------------------------
`define RPL_POLL 8'h50
`define RPL_DIN 8'h51
`define RPL_AIN 8'h52
`define RPL_AOUT 8'h53
`define RPL_DOUT 8'h54
`define RPL_PULSE 8'h55
`define RPL_BATT 8'h56
`define RPL_STORE 8'h57
`define RPL_CHAN 8'h58
`define RPL_POWER 8'h59

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define ALARM_OFF 2'h0
`define ALARM_ON 2'h1
`define ALARM_POLL_CNT 2'h2
`define POWER_LOW 1'b0
`define POWER_HIGH 1'b1

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define REG_NODE_ID 8'h00
`define REG_STATUS 8'h04
`define REG_CHANNEL 8'h08
`define REG_PULSE_COUNT 8'h0c
`define REG_BATT_TRIP 8'h10
`define REG_DOUT 8'h14
`define NODE_ID_RST 8'h01
`define CHANNEL_RST 16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define DWELL_UNIT_NS 10000000
`define DWELL_UNIT_CYC (`DWELL_UNIT_NS / `CLK_PERIOD_NS)

`endif

// [outstation_pkg.sv]
package outstation_pkg;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_SEND = 1'b1
    } st_t;

    typedef struct packed {
        st_t st;
        logic [10:0][7:0] frame;
        logic [3:0] len;
        logic [3:0] idx;
        logic [7:0] node_id;
        logic [3:0][1:0] di_alarm;
        logic [3:0][7:0] di_dwell;
        logic [3:0] di_rise;
        logic [3:0][1:0] ai_type;
        logic [3:0][9:0] ai_trip;
        logic [3:0][7:0] ai_dwell;
        logic [3:0] ai_above;
        logic [3:0][9:0] ao_level;
        logic [7:0] dout;
        logic pulse_en;
        logic [7:0] pulse_dwell;
        logic [9:0] batt_trip;
        logic [15:0] channel;
        logic [15:0] chan_pend;
        logic chan_wait;
        logic tx_high;
        logic store;
        logic [31:0] rdata;
        logic [19:0] tick_cnt;
        logic [7:0] dwell_cnt;
        logic pin_level;
        logic [15:0] pulse_count;
    } state_t;

endpackage

// [outstation_reply_generator_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module outstation_reply_generator_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Command side
    input wire logic CE,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_SRC,
    input wire logic [7:0] CMD_CODE,
    input wire logic [47:0] CMD_ARG,
    input wire logic CMD_READY,
    // Reply side
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_READY,
    // Applied settings
    input wire logic [7:0] DIG_OUT,
    input wire logic [15:0] CHANNEL,
    input wire logic TX_POWER_HIGH,
    input wire logic STORE_PULSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // A command is taken on this edge, whatever its code; only a known code gets a reply
    wire logic taken = CE && CMD_VALID && CMD_READY;
    wire logic known = CMD_CODE inside {[8'h20:8'h29], 8'h31, 8'h32};
    wire logic setcmd = CMD_CODE inside {[8'h20:8'h29]};

    a_lead_byte: assert property (taken && known |=> TX_VALID && TX_DATA == 8'h04)
        else $error("reply does not open with the lead byte");
    a_dest_echo: assert property (taken && known ##1 TX_READY [*2]
        |=> TX_DATA == $past(CMD_SRC, 3))
        else $error("reply destination is not the requester");
    a_reply_code: assert property (taken && setcmd ##1 TX_READY [*3]
        |=> TX_DATA == $past(CMD_CODE, 4) + 8'h30)
        else $error("reply code does not match the command");
    a_frame_close: assert property (TX_VALID && TX_READY && TX_LAST
        |=> !TX_VALID && CMD_READY)
        else $error("frame does not end after the checksum");
    a_stall_hold: assert property (TX_VALID && !TX_READY
        |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("reply byte changed while stalled");
    a_power_first: assert property (taken && CMD_CODE == 8'h29
        |=> TX_POWER_HIGH == $past(CMD_ARG[40]))
        else $error("power not applied before the reply");
    a_chan_late: assert property (TX_VALID |-> $stable(CHANNEL))
        else $error("channel changed during a reply");
    a_store_once: assert property (taken && CMD_CODE == 8'h27
        |=> STORE_PULSE ##1 !STORE_PULSE)
        else $error("store pulse missing or too long");
    a_dout_apply: assert property (taken && CMD_CODE == 8'h24
        |=> DIG_OUT == $past(CMD_ARG[47:40]))
        else $error("digital outputs not applied");
endmodule

bind outstation_reply_generator outstation_reply_generator_checker i_checker (
    .CLK, .RST, .CE, .CMD_VALID, .CMD_SRC, .CMD_CODE, .CMD_ARG, .CMD_READY, .TX_VALID,
    .TX_DATA, .TX_LAST, .TX_READY, .DIG_OUT, .CHANNEL, .TX_POWER_HIGH, .STORE_PULSE
);
`default_nettype wire

// [base_station_model.sv]
`timescale 1ns/1ps
`default_nettype none
module base_station_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Command side
    input wire logic cmd_ready,
    output logic cmd_valid,
    output logic [7:0] cmd_src,
    output logic [7:0] cmd_code,
    output logic [47:0] cmd_arg,
    // Reply side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic [7:0] rx[$];
    int frames = 0;

    // Idle lines show the inverse of the last value
    initial begin
        cmd_valid = 1'b0;
        cmd_src = 8'hff;
        cmd_code = 8'hff;
        cmd_arg = 48'h0;
        tx_ready = 1'b1;
    end

    // Sink collects accepted bytes and stalls every other cycle when slow
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            rx.push_back(tx_data);
            if (tx_last) frames++;
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // Hold one command until the edge that takes it
    task automatic send(input logic [7:0] code, input logic [47:0] arg);
        cmd_valid <= 1'b1;
        cmd_src <= 8'h00;
        cmd_code <= code;
        cmd_arg <= arg;
        do @(negedge clk); while (cmd_ready !== 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_src <= 8'hff;
        cmd_code <= ~code;
        cmd_arg <= ~arg;
    endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pulse_in = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [9:0] battery = 10'h000;
    logic [7:0] node = 8'h01;
    wire logic cmd_valid, cmd_ready, tx_valid, tx_last, tx_ready, power_high, store_pulse;
    wire logic [7:0] cmd_src, cmd_code, tx_data, dig_out;
    wire logic [47:0] cmd_arg;
    wire logic [39:0] ana_out;
    wire logic [15:0] channel;
    wire logic [31:0] reg_rdata;
    int err_count = 0;
    int n_checks = 0;

    // Design with a short dwell tick
    outstation_reply_generator #(.TICK_CYCLES(4)) i_outstation_reply_generator (
        .CLK(clk), .RST(rst), .CE(ce), .CMD_VALID(cmd_valid), .CMD_SRC(cmd_src),
        .CMD_CODE(cmd_code), .CMD_ARG(cmd_arg), .CMD_READY(cmd_ready), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready), .BATTERY_LEVEL(battery),
        .PULSE_IN(pulse_in), .DIG_OUT(dig_out), .ANA_OUT(ana_out), .CHANNEL(channel),
        .TX_POWER_HIGH(power_high), .STORE_PULSE(store_pulse), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    // Far side
    base_station_model i_base_station_model (
        .clk(clk), .slow(slow), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_src(cmd_src), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

    // ------
    // Shared tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic read_reg(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    // Send a command and compare the whole reply frame
    task automatic do_cmd(input logic [7:0] code, input logic [47:0] arg,
                          input logic [7:0] rc, input logic [47:0] pay, input int n);
        logic [7:0] exp[$];
        logic [7:0] sum;
        int f0;
        exp = '{8'h04, node, 8'h00, rc};
        sum = rc;
        for (int i = 0; i < n; i++) begin
            exp.push_back(pay[47 - 8 * i -: 8]);
            sum += pay[47 - 8 * i -: 8];
        end
        exp.push_back(sum);
        f0 = i_base_station_model.frames;
        i_base_station_model.rx.delete();
        i_base_station_model.send(code, arg);
        for (int t = 0; t < 300 && i_base_station_model.frames == f0; t++) @(negedge clk);
        @(posedge clk);
        #1;
        check(32'(i_base_station_model.rx.size()), 32'(exp.size()));
        foreach (exp[i]) check(32'(i_base_station_model.rx[i]), 32'(exp[i]));
    endtask
    task automatic pulse(input int n);
        pulse_in <= 1'b1;
        repeat (n) @(posedge clk);
        pulse_in <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        read_reg(8'h00, 32'h1);
        read_reg(8'h08, 32'h1);
        read_reg(8'h04, 32'h0);
        read_reg(8'h40, 32'h0);
        write_reg(8'h00, 32'h7);
        node = 8'h07;
        read_reg(8'h00, 32'h7);
    endtask
    // Clock enable low: writes are dropped and read data holds its last value
    task automatic t_freeze;
        ce <= 1'b0;
        write_reg(8'h00, 32'h55);
        read_reg(8'h08, 32'h7);
        ce <= 1'b1;
        read_reg(8'h00, 32'h7);
    endtask
    task automatic t_poll;
        battery <= 10'h2c5;
        slow <= 1'b1;
        do_cmd(8'h20, 48'h0, 8'h50, 48'h02c5_0000_0000, 2);
        slow <= 1'b0;
        battery <= 10'h3ff;
        do_cmd(8'h20, 48'h0, 8'h50, 48'h03ff_0000_0000, 2);
    endtask
    task automatic t_din;
        do_cmd(8'h21, 48'h0101_ff01_0000, 8'h51, 48'h0101_ff01_0000, 4);
        do_cmd(8'h21, 48'h0102_0000_0000, 8'h51, 48'h0102_0000_0000, 4);
        do_cmd(8'h21, 48'h0402_0501_0000, 8'h51, 48'h0400_0501_0000, 4);
        do_cmd(8'h31, 48'h0100_0000_0000, 8'h51, 48'h0102_0000_0000, 4);
    endtask
    task automatic t_ain;
        logic [15:0] trip;
        logic [47:0] a;
        for (int t = 1; t <= 3; t++) begin
            trip = (t == 1) ? 16'h0000 : (t == 2) ? 16'h0001 : 16'h03ff;
            a = {8'h01 << t, 8'(t), trip, 8'(t), 8'(t % 2)};
            do_cmd(8'h22, a, 8'h52, a, 6);
        end
        do_cmd(8'h32, 48'h0400_0000_0000, 8'h52, 48'h0402_0001_0200, 6);
    endtask
    task automatic t_outputs;
        do_cmd(8'h23, 48'h0303_ff00_0000, 8'h53, 48'h0303_ff00_0000, 3);
        check(32'(ana_out[39:30]), 32'h3ff);
        do_cmd(8'h24, 48'ha500_0000_0000, 8'h54, 48'ha500_0000_0000, 1);
        check(32'(dig_out), 32'ha5);
        read_reg(8'h14, 32'ha5);
        do_cmd(8'h26, 48'h03ff_0000_0000, 8'h56, 48'h03ff_0000_0000, 2);
        read_reg(8'h10, 32'h3ff);
        do_cmd(8'h27, 48'h0, 8'h57, 48'h0, 0);
    endtask
    task automatic t_pulse;
        do_cmd(8'h25, 48'h0102_0000_0000, 8'h55, 48'h0102_0000_0000, 2);
        repeat (3) pulse(30);
        pulse(3);
        read_reg(8'h0c, 32'h3);
        write_reg(8'h0c, 32'h0);
        read_reg(8'h0c, 32'h0);
        do_cmd(8'h25, 48'h0, 8'h55, 48'h0, 2);
        pulse(30);
        read_reg(8'h0c, 32'h0);
    endtask
    task automatic t_chan_power;
        check(32'(channel), 32'h1);
        do_cmd(8'h28, 48'h0190_0000_0000, 8'h58, 48'h0190_0000_0000, 2);
        repeat (2) @(posedge clk);
        #1;
        check(32'(channel), 32'h190);
        for (int p = 1; p >= 0; p--) begin
            do_cmd(8'h29, {8'(p), 40'h0}, 8'h59, {8'(p), 40'h0}, 1);
            check(32'(power_high), 32'(p));
            read_reg(8'h04, 32'(p * 2));
        end
    endtask

    // Clock
    initial begin
        forever #10 clk = ~clk;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_regs();
        t_freeze();
        t_poll();
        t_din();
        t_ain();
        t_outputs();
        t_pulse();
        t_chan_power();
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
